// >>> rtl/psmb_pkg.sv
// Constants, counts and types shared by the SMBus target interface.
// Assumes a 100 MHz system clock; the stretch, timeout and programming counts are derived from it here.
package psmb_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_RATE_KBPS = 100;

  // Longest clock stretch, rounded down to whole cycles.
  localparam int STRETCH_MAX_NS = 1000000;
  localparam int STRETCH_CYC    = STRETCH_MAX_NS / CLK_PERIOD_NS;

  // Least SCL-low time before the transfer is abandoned, rounded up.
  localparam int TIMEOUT_NS  = 25000000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least internal programming time after a storage write, rounded up.
  localparam int EE_PROG_NS  = 5000000;
  localparam int EE_PROG_CYC = (EE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 22;

  localparam logic [7:0] CTRL_BASE_ADDR = 8'hb0;
  localparam logic [7:0] CTRL_OPEN_ADDR = 8'hb6;
  localparam logic [7:0] EE_ADDR_OFFSET = 8'h10;
  localparam logic [7:0] ALERT_RSP_ADDR = 8'h19;
  localparam logic [7:0] IDLE_BYTE      = 8'hff;

  // Command plus one 16-bit word, and the block transfer ceiling.
  localparam logic [7:0] PSMI_WR_LEN   = 8'h03;
  localparam logic [7:0] PSMI_RD_LEN   = 8'h02;
  localparam logic [7:0] BLOCK_MAX_LEN = 8'hff;

  localparam int EE_DEPTH = 256;

  // Cycles after reset release before the strap is caught.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum {
    ST_IDLE, ST_RX, ST_ACK, ST_LOAD, ST_TX, ST_RACK, ST_IGNORE
  } psmb_state_t;

  typedef enum {TGT_NONE, TGT_CTRL, TGT_EE, TGT_ARA} psmb_target_t;

endpackage

// >>> rtl/psmb_slave.sv
// SMBus target interface of a power supply: address and protocol strap,
// controller byte port, 256-byte user storage, alert line and response.
// Assumes open-drain SCL/SDA resolved outside; SCL also clocks the link side.
`timescale 1ns/10ps
`default_nettype none

module psmb_slave #(
  parameter int STRETCH_CYC = psmb_pkg::STRETCH_CYC,
  parameter int TIMEOUT_CYC = psmb_pkg::TIMEOUT_CYC,
  parameter int EE_PROG_CYC = psmb_pkg::EE_PROG_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_clk_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_proto_strap_open_i,
  input  wire logic [2:0] addr_proto_strap_code_i,
  input  wire logic       ac_present_i,
  input  wire logic       main_output_rail_i,
  input  wire logic       shutdown_evt_i,
  input  wire logic       warning_evt_i,
  input  wire logic [7:0] status_byte_i,
  input  wire logic       ee_wp_off_i,
  input  wire logic       ee_wp_on_i,
  output logic            fault_alert_n_o,
  output logic            proto_psmi_o,
  output logic [7:0]      ctrl_addr_o,
  output logic [7:0]      ee_addr_o,
  output logic            ee_wp_o,
  output logic            ctrl_wr_stb_o,
  output logic [7:0]      ctrl_wr_byte_o,
  output logic [7:0]      ctrl_idx_o,
  output logic            ctrl_rd_req_o,
  input  wire logic       ctrl_rd_ack_i,
  input  wire logic [7:0] ctrl_rd_byte_i,
  output logic            ctrl_stop_o
);

  localparam int CW = psmb_pkg::CNT_W;
  localparam logic [CW-1:0] STR_LAST = CW'(STRETCH_CYC - 1);
  localparam logic [CW-1:0] TMO_LAST = CW'(TIMEOUT_CYC - 1);
  localparam logic [CW-1:0] EE_PROG  = CW'(EE_PROG_CYC);

  // Controller address chosen by the strap resistor code.
  function automatic logic [7:0] strap_addr(input logic open,
                                            input logic [2:0] code);
    if (open) begin
      strap_addr = psmb_pkg::CTRL_OPEN_ADDR;
    end else begin
      strap_addr = psmb_pkg::CTRL_BASE_ADDR + {5'h00, code[1:0], 1'b0};
    end
  endfunction

  // Link side: each rising SCL edge samples SDA and flips a toggle.
  logic link_tgl_r;
  logic link_sda_r;

  always_ff @(posedge scl_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_tgl_r <= 1'b0;
      link_sda_r <= 1'b1;
    end else begin
      link_tgl_r <= ~link_tgl_r;
      link_sda_r <= sda_i;
    end
  end

  // System side synchronisers.
  logic       scl_s1, scl_s2, scl_d_r;
  logic       sda_s1, sda_s2, sda_d_r;
  logic       tgl_s1, tgl_s2, tgl_d_r;
  logic       en_s1, en_s2;
  logic       sop_s1, sop_s2;
  logic [2:0] scd_s1, scd_s2;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_s1, scl_s2, scl_d_r} <= 3'h7;
      {sda_s1, sda_s2, sda_d_r} <= 3'h7;
      {tgl_s1, tgl_s2, tgl_d_r} <= 3'h0;
      {en_s1, en_s2}            <= 2'h0;
      {sop_s1, sop_s2}          <= 2'h0;
      scd_s1                    <= 3'h0;
      scd_s2                    <= 3'h0;
    end else begin
      scl_s1  <= scl_clk_i;
      scl_s2  <= scl_s1;
      scl_d_r <= scl_s2;
      sda_s1  <= sda_i;
      sda_s2  <= sda_s1;
      sda_d_r <= sda_s2;
      tgl_s1  <= link_tgl_r;
      tgl_s2  <= tgl_s1;
      tgl_d_r <= tgl_s2;
      en_s1   <= ac_present_i | main_output_rail_i;
      en_s2   <= en_s1;
      sop_s1  <= addr_proto_strap_open_i;
      sop_s2  <= sop_s1;
      scd_s1  <= addr_proto_strap_code_i;
      scd_s2  <= scd_s1;
    end
  end

  // The sampled SDA bit is stable for a whole SCL period after its toggle.
  logic bit_stb, bit_val, scl_fall, start_det, stop_det;
  assign bit_stb   = tgl_s2 ^ tgl_d_r;
  assign bit_val   = link_sda_r;
  assign scl_fall  = scl_d_r & ~scl_s2;
  assign start_det = scl_s2 & scl_d_r & sda_d_r & ~sda_s2;
  assign stop_det  = scl_s2 & scl_d_r & ~sda_d_r & sda_s2;

  // Strap caught once after reset release, then frozen.
  logic [1:0] strap_cnt_r;
  logic       strap_done_r;
  logic       proto_psmi_r;
  logic [7:0] ctrl_addr_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
      proto_psmi_r <= 1'b1;
      ctrl_addr_r  <= psmb_pkg::CTRL_OPEN_ADDR;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == psmb_pkg::STRAP_SETTLE) begin
        strap_done_r <= 1'b1;
        proto_psmi_r <= sop_s2 | scd_s2[2];
        ctrl_addr_r  <= strap_addr(sop_s2, scd_s2);
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  assign proto_psmi_o = proto_psmi_r;
  assign ctrl_addr_o  = ctrl_addr_r;
  assign ee_addr_o    = ctrl_addr_r - psmb_pkg::EE_ADDR_OFFSET;

  // Fault alert and storage write protection.
  logic alert_n_r, wp_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_n_r <= 1'b1;
    end else begin
      alert_n_r <= ~(shutdown_evt_i | warning_evt_i);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= 1'b1;
    end else if (ee_wp_on_i) begin
      wp_r <= 1'b1;
    end else if (ee_wp_off_i) begin
      wp_r <= 1'b0;
    end
  end

  assign fault_alert_n_o = alert_n_r;
  assign ee_wp_o         = wp_r;

  // Protocol engine state.
  psmb_pkg::psmb_state_t  state_r;
  psmb_pkg::psmb_target_t target_r, hit_tgt;
  logic [7:0] sr_r, tx_r, idx_r, rx_byte, len_lim, ee_rdata, load_byte;
  logic [2:0] bit_cnt_r;
  logic       first_r, rw_r, ack_ok_r, rx_done_r, scl_oe_r, sda_oe_r;
  logic       wr_ok, ee_busy, byte_end, wr_commit, load_ready, load_done;
  logic       ee_wrote_r, rd_req_r;
  logic [CW-1:0] tmo_cnt_r, str_cnt_r, ee_busy_r;
  logic       timeout;

  assign rx_byte  = {sr_r[6:0], bit_val};
  assign byte_end = (state_r == psmb_pkg::ST_RX) & bit_stb & (bit_cnt_r == 3'h7);
  assign ee_busy  = (ee_busy_r != '0);
  assign timeout  = (state_r != psmb_pkg::ST_IDLE) & ~scl_s2
                    & (tmo_cnt_r >= TMO_LAST);
  assign len_lim  = proto_psmi_r ? psmb_pkg::PSMI_WR_LEN
                                 : psmb_pkg::BLOCK_MAX_LEN;

  always_comb begin
    hit_tgt = psmb_pkg::TGT_NONE;
    if (rx_byte[7:1] == ctrl_addr_r[7:1]) begin
      hit_tgt = psmb_pkg::TGT_CTRL;
    end else if ((rx_byte[7:1] == ee_addr_o[7:1]) && !ee_busy) begin
      hit_tgt = psmb_pkg::TGT_EE;
    end else if ((rx_byte == psmb_pkg::ALERT_RSP_ADDR) && !alert_n_r) begin
      hit_tgt = psmb_pkg::TGT_ARA;
    end
  end

  // Data byte acceptance: word-sized in PSMI, pointer always, data only while unprotected.
  always_comb begin
    wr_ok = 1'b0;
    if (target_r == psmb_pkg::TGT_CTRL) begin
      wr_ok = (idx_r < len_lim);
    end else if (target_r == psmb_pkg::TGT_EE) begin
      wr_ok = (idx_r == 8'h00) | ~wp_r;
    end
  end
  assign wr_commit = byte_end & ~first_r & wr_ok;

  // Byte to send: storage, status, or the controller's answer.
  always_comb begin
    load_byte  = psmb_pkg::IDLE_BYTE;
    load_ready = 1'b1;
    case (target_r)
      psmb_pkg::TGT_EE: load_byte = ee_rdata;
      psmb_pkg::TGT_ARA: load_byte = status_byte_i;
      psmb_pkg::TGT_CTRL: begin
        if (idx_r < (proto_psmi_r ? psmb_pkg::PSMI_RD_LEN
                                  : psmb_pkg::BLOCK_MAX_LEN)) begin
          load_byte  = ctrl_rd_byte_i;
          load_ready = ctrl_rd_ack_i;
        end
      end
      default: load_byte = psmb_pkg::IDLE_BYTE;
    endcase
    if (str_cnt_r >= STR_LAST) begin
      load_byte  = psmb_pkg::IDLE_BYTE;
      load_ready = 1'b1;
    end
  end
  assign load_done = (state_r == psmb_pkg::ST_LOAD) & load_ready;

  // Bus engine. It only answers a master and drives nothing from idle.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r   <= psmb_pkg::ST_IDLE;
      target_r  <= psmb_pkg::TGT_NONE;
      sr_r      <= 8'h00;
      tx_r      <= 8'h00;
      idx_r     <= 8'h00;
      bit_cnt_r <= 3'h0;
      first_r   <= 1'b0;
      rw_r      <= 1'b0;
      ack_ok_r  <= 1'b0;
      rx_done_r <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      rd_req_r  <= 1'b0;
    end else begin
      rd_req_r <= 1'b0;
      if (!en_s2 || !strap_done_r || timeout || stop_det) begin
        state_r  <= psmb_pkg::ST_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (start_det) begin
        state_r   <= psmb_pkg::ST_RX;
        first_r   <= 1'b1;
        bit_cnt_r <= 3'h0;
        idx_r     <= 8'h00;
        rx_done_r <= 1'b0;
        scl_oe_r  <= 1'b0;
        sda_oe_r  <= 1'b0;
      end else begin
        case (state_r)
          psmb_pkg::ST_RX: begin
            if (bit_stb) begin
              sr_r      <= rx_byte;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h7) begin
                rx_done_r <= 1'b1;
                if (first_r) begin
                  target_r <= hit_tgt;
                  rw_r     <= rx_byte[0];
                  ack_ok_r <= (hit_tgt != psmb_pkg::TGT_NONE)
                              & (rx_byte[0] | hit_tgt != psmb_pkg::TGT_ARA);
                end else begin
                  ack_ok_r <= wr_ok;
                end
              end
            end else if (scl_fall && rx_done_r) begin
              rx_done_r <= 1'b0;
              sda_oe_r  <= ack_ok_r;
              state_r   <= ack_ok_r ? psmb_pkg::ST_ACK : psmb_pkg::ST_IGNORE;
            end
          end
          psmb_pkg::ST_ACK: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              if (!first_r) begin
                idx_r <= idx_r + 8'h01;
              end
              first_r <= 1'b0;
              if (rw_r) begin
                scl_oe_r <= 1'b1;
                rd_req_r <= 1'b1;
                state_r  <= psmb_pkg::ST_LOAD;
              end else begin
                state_r <= psmb_pkg::ST_RX;
              end
            end
          end
          psmb_pkg::ST_LOAD: begin
            if (load_ready) begin
              tx_r      <= load_byte;
              sda_oe_r  <= ~load_byte[7];
              scl_oe_r  <= 1'b0;
              bit_cnt_r <= 3'h0;
              idx_r     <= idx_r + 8'h01;
              state_r   <= psmb_pkg::ST_TX;
            end
          end
          psmb_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == 3'h7) begin
                sda_oe_r <= 1'b0;
                state_r  <= psmb_pkg::ST_RACK;
              end else begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                tx_r      <= {tx_r[6:0], 1'b0};
                sda_oe_r  <= ~tx_r[6];
              end
            end
          end
          psmb_pkg::ST_RACK: begin
            if (bit_stb) begin
              ack_ok_r <= ~bit_val;
            end else if (scl_fall) begin
              scl_oe_r <= ack_ok_r;
              rd_req_r <= ack_ok_r;
              state_r  <= ack_ok_r ? psmb_pkg::ST_LOAD : psmb_pkg::ST_IGNORE;
            end
          end
          default: begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_oe_r;
  assign sda_oe_o = sda_oe_r;

  // SCL-low, stretch and storage programming timers.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_cnt_r <= '0;
      str_cnt_r <= '0;
      ee_busy_r <= '0;
    end else begin
      tmo_cnt_r <= (scl_s2 || state_r == psmb_pkg::ST_IDLE) ? '0
                   : tmo_cnt_r + CW'(1);
      str_cnt_r <= (state_r == psmb_pkg::ST_LOAD && !load_ready)
                   ? str_cnt_r + CW'(1) : '0;
      if (stop_det && ee_wrote_r) begin
        ee_busy_r <= EE_PROG;
      end else if (ee_busy) begin
        ee_busy_r <= ee_busy_r - CW'(1);
      end
    end
  end

  // User storage and its address pointer.
  logic [7:0] ee_mem [psmb_pkg::EE_DEPTH];
  logic [7:0] ee_ptr_r;
  assign ee_rdata = ee_mem[ee_ptr_r];

  always_ff @(posedge sys_clk_i) begin
    if (wr_commit && target_r == psmb_pkg::TGT_EE && idx_r != 8'h00) begin
      ee_mem[ee_ptr_r] <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ee_ptr_r   <= 8'h00;
      ee_wrote_r <= 1'b0;
    end else if (stop_det) begin
      ee_wrote_r <= 1'b0;
    end else if (wr_commit && target_r == psmb_pkg::TGT_EE) begin
      ee_ptr_r   <= (idx_r == 8'h00) ? rx_byte : ee_ptr_r + 8'h01;
      ee_wrote_r <= (idx_r != 8'h00);
    end else if (load_done && target_r == psmb_pkg::TGT_EE) begin
      ee_ptr_r <= ee_ptr_r + 8'h01;
    end
  end

  // Controller byte port; no error-check byte is added or expected.
  logic       wr_stb_r, stop_r;
  logic [7:0] wr_byte_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_stb_r  <= 1'b0;
      wr_byte_r <= 8'h00;
      stop_r    <= 1'b0;
    end else begin
      wr_stb_r <= wr_commit & (target_r == psmb_pkg::TGT_CTRL);
      stop_r   <= stop_det & (target_r == psmb_pkg::TGT_CTRL)
                  & (state_r != psmb_pkg::ST_IDLE);
      if (wr_commit) begin
        wr_byte_r <= rx_byte;
      end
    end
  end

  assign ctrl_wr_stb_o  = wr_stb_r;
  assign ctrl_wr_byte_o = wr_byte_r;
  assign ctrl_idx_o     = idx_r;
  assign ctrl_rd_req_o  = rd_req_r & (target_r == psmb_pkg::TGT_CTRL);
  assign ctrl_stop_o    = stop_r;

  // Checks.
  property p_idle_quiet;
    @(posedge sys_clk_i) disable iff (rst_i)
    state_r == psmb_pkg::ST_IDLE |=> !scl_oe_o || state_r != psmb_pkg::ST_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("Target drives SCL while idle.");

  property p_stretch_bound;
    @(posedge sys_clk_i) disable iff (rst_i)
    scl_oe_o |-> str_cnt_r <= STR_LAST;
  endproperty
  a_stretch_bound: assert property (p_stretch_bound)
    else $error("Clock stretch exceeds its limit.");

  property p_timeout_abort;
    @(posedge sys_clk_i) disable iff (rst_i)
    timeout |=> state_r == psmb_pkg::ST_IDLE && !sda_oe_o && !scl_oe_o;
  endproperty
  a_timeout_abort: assert property (p_timeout_abort)
    else $error("SCL timeout did not abandon the transfer.");

  property p_start_restart;
    @(posedge sys_clk_i) disable iff (rst_i)
    start_det && en_s2 && strap_done_r && !stop_det
    |=> state_r == psmb_pkg::ST_RX && first_r && !sda_oe_o;
  endproperty
  a_start_restart: assert property (p_start_restart)
    else $error("START did not restart the engine.");

  property p_alert_or;
    @(posedge sys_clk_i) disable iff (rst_i)
    (shutdown_evt_i || warning_evt_i) |=> !fault_alert_n_o ##1 1'b1;
  endproperty
  a_alert_or: assert property (p_alert_or)
    else $error("Alert not raised for an event.");

  property p_ara_status;
    @(posedge sys_clk_i) disable iff (rst_i)
    load_done && target_r == psmb_pkg::TGT_ARA && str_cnt_r < STR_LAST
    |=> tx_r == $past(status_byte_i);
  endproperty
  a_ara_status: assert property (p_ara_status)
    else $error("Alert response did not return status.");

  property p_off_silent;
    @(posedge sys_clk_i) disable iff (rst_i)
    !en_s2 |=> !sda_oe_o && !scl_oe_o;
  endproperty
  a_off_silent: assert property (p_off_silent)
    else $error("Bus driven while interface unpowered.");

  property p_strap_open;
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(strap_done_r) && $past(sop_s2)
    |-> ctrl_addr_r == psmb_pkg::CTRL_OPEN_ADDR && proto_psmi_r;
  endproperty
  a_strap_open: assert property (p_strap_open)
    else $error("Open strap gave wrong address or protocol.");

  property p_strap_frozen;
    @(posedge sys_clk_i) disable iff (rst_i)
    strap_done_r |=> $stable(ctrl_addr_r) && $stable(proto_psmi_r);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen)
    else $error("Strap selection changed after start-up.");

  property p_wp_refuse;
    @(posedge sys_clk_i) disable iff (rst_i)
    byte_end && !first_r && target_r == psmb_pkg::TGT_EE
    && idx_r != 8'h00 && wp_r |=> !ack_ok_r;
  endproperty
  a_wp_refuse: assert property (p_wp_refuse)
    else $error("Protected storage write acknowledged.");

  property p_psmi_word;
    @(posedge sys_clk_i) disable iff (rst_i)
    byte_end && !first_r && proto_psmi_r && target_r == psmb_pkg::TGT_CTRL
    && idx_r >= psmb_pkg::PSMI_WR_LEN
    |=> !ack_ok_r;
  endproperty
  a_psmi_word: assert property (p_psmi_word)
    else $error("PSMI write longer than one word acknowledged.");

  property p_foreign_nack;
    @(posedge sys_clk_i) disable iff (rst_i)
    byte_end && first_r && hit_tgt == psmb_pkg::TGT_NONE |=> !ack_ok_r;
  endproperty
  a_foreign_nack: assert property (p_foreign_nack)
    else $error("Foreign address acknowledged.");

endmodule // psmb_slave

`default_nettype wire

// >>> test/psmb_host_model.sv
// Host model for the SMBus target: START, STOP, byte write and read.
// Assumes pull-ups on both wires; the target pulls low via its enables.
`timescale 1ns/10ps
`default_nettype none
module psmb_host_model (
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      stuck_o
);
  logic m_scl_r;
  logic m_sda_r;
  assign scl_o = m_scl_r & ~scl_oe_i;
  assign sda_o = m_sda_r & ~sda_oe_i;
  initial begin
    m_scl_r = 1'b1;
    m_sda_r = 1'b1;
    stuck_o = 1'b0;
  end
  // Data changes only while SCL is low; a stretched clock is waited out.
  task automatic bit_io(input logic b, output logic r);
    int n;
    n = 0;
    m_sda_r = b;
    #160 m_scl_r = 1'b1;
    while (scl_o !== 1'b1 && n < 2000) begin
      #10 n++;
    end
    if (n == 2000) stuck_o = 1'b1;
    #160 r = sda_o;
    #160 m_scl_r = 1'b0;
    #160;
  endtask
  task automatic start();
    m_sda_r = 1'b1;
    #160 m_scl_r = 1'b1;
    #160 m_sda_r = 1'b0;
    #160 m_scl_r = 1'b0;
    #160;
  endtask
  task automatic stop();
    m_sda_r = 1'b0;
    #160 m_scl_r = 1'b1;
    #160 m_sda_r = 1'b1;
    #320;
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // psmb_host_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench: strap, alert, storage, controller port, timeout.
// Assumes the host model drives the far side of the two-wire bus.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk, rst, op, ac, rail, sd, wn, wp_off, wp_on, rd_ack, a;
  logic [2:0] code;
  logic [7:0] st_b, rd_b, v, wb, rv, wi, cidx;
  logic [2:0] ab;
  logic       cstop;
  logic       scl, sda, scl_oe, sda_oe, alert_n, psmi, wp, wstb, rreq, stk;
  logic [7:0] caddr, eaddr, wbyte;
  int         errors, checked, seed, nstop;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  psmb_host_model u_mst (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
    .scl_o(scl), .sda_o(sda), .stuck_o(stk));
  psmb_slave #(.STRETCH_CYC(50), .TIMEOUT_CYC(400), .EE_PROG_CYC(100))
  u_dut (.sys_clk_i(clk), .rst_i(rst), .scl_clk_i(scl), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .addr_proto_strap_open_i(op), .addr_proto_strap_code_i(code),
    .ac_present_i(ac), .main_output_rail_i(rail), .shutdown_evt_i(sd),
    .warning_evt_i(wn), .status_byte_i(st_b), .ee_wp_off_i(wp_off),
    .ee_wp_on_i(wp_on), .fault_alert_n_o(alert_n), .proto_psmi_o(psmi),
    .ctrl_addr_o(caddr), .ee_addr_o(eaddr), .ee_wp_o(wp),
    .ctrl_wr_stb_o(wstb), .ctrl_wr_byte_o(wbyte), .ctrl_idx_o(cidx),
    .ctrl_rd_req_o(rreq), .ctrl_rd_ack_i(rd_ack),
    .ctrl_rd_byte_i(rd_b), .ctrl_stop_o(cstop));
  // Controller stand-in answers each read request after a short delay.
  always @(posedge clk) begin
    if (wstb) {wi, wb} <= {cidx, wbyte};
    if (rreq) begin
      repeat (5) @(posedge clk);
      #1 rd_ack = 1'b1;
      @(posedge clk);
      #1 rd_ack = 1'b0;
    end
  end
  // Counts STOPs that end a controller transaction.
  always @(posedge clk) begin
    if (cstop) nstop <= nstop + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // The strap is flipped after capture; outputs must not follow it.
  task automatic do_reset(input logic o, input logic [2:0] c);
    rst = 1'b1;
    op = o;
    code = c;
    tick(20);
    rst = 1'b0;
    tick(10);
    code = ~c;
    op = ~o;
    tick(5);
  endtask
  task automatic xfer(input logic [7:0] ad, input logic [7:0] b);
    u_mst.start();
    u_mst.wr(ad, a);
    ab[2] = a;
    u_mst.wr(b, ab[1]);
    u_mst.wr(8'($random(seed)), ab[0]);
  endtask
  initial begin
    seed = 32'h7a0e9fff;
    {ac, rail, sd, wn, wp_off, wp_on, rd_ack} = 7'h40;
    {st_b, rd_b, wb, errors, checked, nstop} = '0;
    for (int c = 0; c < 8; c++) begin
      do_reset(1'b0, c[2:0]);
      chk(psmi, c >= 4);
      chk(caddr, 8'hb0 + 8'(2 * (c % 4)));
      chk(eaddr, 8'ha0 + 8'(2 * (c % 4)));
    end
    do_reset(1'b1, 3'h2);
    chk({psmi, wp, alert_n, caddr, eaddr}, 19'h7b6a6);
    for (int i = 0; i < 12; i++) begin
      {sd, wn} = 2'($random(seed));
      tick(3);
      chk(alert_n, !(sd || wn));
      u_mst.start();
      u_mst.wr({2'b01, 6'($random(seed))}, a);
      u_mst.stop();
      chk(a, 1'b0);
    end
    {sd, wn} = 2'b10;
    st_b = 8'($random(seed));
    u_mst.start();
    u_mst.wr(8'h19, a);
    u_mst.rd(1'b1, v);
    u_mst.stop();
    chk({a, v}, {1'b1, st_b});
    sd = 1'b0;
    {ac, rail} = 2'b00;
    tick(5);
    u_mst.start();
    u_mst.wr(8'hb6, a);
    u_mst.stop();
    chk(a, 1'b0);
    rail = 1'b1;
    tick(5);
    xfer(8'ha6, 8'hff);
    u_mst.stop();
    chk(ab, 3'b110);
    wp_off = 1'b1;
    tick(1);
    wp_off = 1'b0;
    tick(2);
    chk(wp, 1'b0);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      u_mst.start();
      u_mst.wr(8'ha6, ab[2]);
      u_mst.wr(v, ab[1]);
      u_mst.wr(v ^ 8'h5a, ab[0]);
      u_mst.stop();
      chk(ab, 3'b111);
      tick(120);
      u_mst.start();
      u_mst.wr(8'ha6, a);
      u_mst.wr(v, a);
      u_mst.start();
      u_mst.wr(8'ha7, a);
      u_mst.rd(1'b1, rv);
      u_mst.stop();
      chk({a, rv}, {1'b1, v ^ 8'h5a});
    end
    rd_b = 8'($random(seed));
    u_mst.start();
    u_mst.wr(8'hb7, a);
    u_mst.rd(1'b1, v);
    u_mst.stop();
    chk({a, v}, {1'b1, rd_b});
    xfer(8'hb6, 8'h3c);
    u_mst.wr(8'h96, a);
    u_mst.wr(8'h11, ab[0]);
    u_mst.stop();
    chk({ab[2:1], a, ab[0], wb}, 12'he96);
    chk(wi, 8'h02);
    u_mst.start();
    v = 8'hb6;
    for (int i = 7; i >= 0; i--) u_mst.bit_io(v[i], a);
    tick(100);
    chk(sda_oe, 1'b1);
    tick(400);
    chk({scl_oe, sda_oe}, 2'b00);
    u_mst.start();
    u_mst.wr(8'hb6, a);
    u_mst.stop();
    chk({a, stk}, 2'b10);
    wp_on = 1'b1;
    tick(1);
    wp_on = 1'b0;
    tick(2);
    chk(wp, 1'b1);
    chk(24'(nstop), 24'h3);
    give_verdict();
  end
  initial begin
    #900000;
    errors++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire
